// File: bench/lnbr_host.sv
`timescale 1ns/10ps
module lnbr_host (input wire CORE_CLK, output reg SCL_PIN, WR_ARMED,
  output reg [7:0] WR_ADDR, WR_DATA);
  initial {SCL_PIN, WR_ARMED, WR_ADDR, WR_DATA} = 18'h20000;
  task wr(input [7:0] a, d);
    begin
      // idle high first so the synced clock sees a real fall
      repeat (3) @(posedge CORE_CLK);
      #1 {SCL_PIN, WR_ARMED, WR_ADDR, WR_DATA} = {2'h3, a, d};
      repeat (2) @(posedge CORE_CLK);
      #1 SCL_PIN = 1'b0;
      repeat (6) @(posedge CORE_CLK);
      #1 {SCL_PIN, WR_ARMED, WR_DATA} = {2'h2, ~d};
    end
  endtask
  // pin-mode level select shares the bus clock pin
  task scl(input v);
    begin
      SCL_PIN = v;
    end
  endtask
endmodule // lnbr_host

// File: bench/lnbr_regs_tb.sv
`timescale 1ns/10ps
module lnbr_regs_tb;
  reg CORE_CLK = 1'b0, RSTN = 1'b0, EN_PIN = 1'b1, VCTRL_PIN = 1'b0;
  reg [7:0] RD_ADDR = 8'h00, d;
  wire SCL_PIN, WR_ARMED, WR_DONE, WR_REFUSED, BUS_CONTROL, LIGHT_LOAD_FORCED;
  wire DOUBLE_RATE_TONE, TONE_SWING_HIGH, OUT_ENABLE;
  wire [7:0] WR_ADDR, WR_DATA, RD_DATA;
  wire [3:0] LEVEL_CODE;
  integer error_cnt = 0, checks = 0, cyc = 0, i;
  integer done_cnt = 0, ref_cnt = 0;
  // row: {register index, data byte, expected level code}
  reg [12:0] rows [0:17];
  reg [12:0] row;
  lnbr_host lnbr_host_inst (.*);
  lnbr_regs lnbr_regs_inst (.*);
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task summarize;
    begin
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task chk(input ok);
    begin
      checks = checks + 1;
      if (ok !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0t output differs", $time);
      end
    end
  endtask
  task rd(input [7:0] a, e);
    begin
      RD_ADDR = a;
      repeat (2) @(posedge CORE_CLK);
      #1 chk(RD_DATA === e);
    end
  endtask
  always @(posedge CORE_CLK) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %0t timeout", $time);
      summarize;
    end
  end
  always @(posedge CORE_CLK) begin
    if (WR_DONE === 1'b1) done_cnt = done_cnt + 1;
    if (WR_REFUSED === 1'b1) ref_cnt = ref_cnt + 1;
  end
  initial begin
    // rows 0..15 walk every level code, 16..17 the second register
    rows[0] = 13'h0800;
    rows[1] = 13'h0831;
    rows[2] = 13'h0c42;
    rows[3] = 13'h0c73;
    rows[4] = 13'h0a84;
    rows[5] = 13'h0ab5;
    rows[6] = 13'h0ec6;
    rows[7] = 13'h0ef7;
    rows[8] = 13'h0908;
    rows[9] = 13'h0939;
    rows[10] = 13'h0d4a;
    rows[11] = 13'h0d7b;
    rows[12] = 13'h0b8c;
    rows[13] = 13'h0bbd;
    rows[14] = 13'h0fce;
    rows[15] = 13'h0fff;
    rows[16] = 13'h108f;
    rows[17] = 13'h180f;
    repeat (10) @(posedge CORE_CLK);
    #1 chk(LEVEL_CODE === 4'h4 && OUT_ENABLE === 1'b0);
    RSTN = 1'b1;
    rd(8'h00, 8'h08);
    rd(8'h01, 8'h08);
    for (i = 0; i < 18; i = i + 1) begin
      row = rows[i];
      d = row[11:4];
      lnbr_host_inst.wr({7'h00, row[12]}, d);
      rd({7'h00, row[12]}, d);
      chk(LEVEL_CODE === row[3:0]);
      if (row[12] == 1'b0) chk(LIGHT_LOAD_FORCED === d[6] && DOUBLE_RATE_TONE === d[0]);
      else chk(TONE_SWING_HIGH === d[7] && OUT_ENABLE === d[3]);
    end
    chk(done_cnt == 18 && ref_cnt == 0);
    lnbr_host_inst.wr(8'h02, 8'hff);
    chk(ref_cnt == 1 && done_cnt == 18);
    rd(8'h02, 8'h00);
    rd(8'h01, 8'h80);
    lnbr_host_inst.wr(8'h01, 8'h08);
    lnbr_host_inst.wr(8'h00, 8'h20);
    rd(8'h00, 8'h20);
    for (i = 0; i < 8; i = i + 1) begin
      lnbr_host_inst.scl(i[1]);
      VCTRL_PIN = i[0];
      EN_PIN = i[2];
      repeat (5) @(posedge CORE_CLK);
      #1 chk(LEVEL_CODE === {i[0], 1'b1, i[1], 1'b0} && OUT_ENABLE === i[2]);
    end
    // second reset in mid-run, pins left high
    RSTN = 1'b0;
    repeat (2) @(posedge CORE_CLK);
    #1 chk(LEVEL_CODE === 4'h4 && OUT_ENABLE === 1'b0 && BUS_CONTROL === 1'b0);
    chk(RD_DATA === 8'h00 && TONE_SWING_HIGH === 1'b0);
    RSTN = 1'b1;
    rd(8'h00, 8'h08);
    rd(8'h01, 8'h08);
    chk(ref_cnt == 1 && done_cnt == 20);
    summarize;
  end
endmodule // lnbr_regs_tb

// File: bench/lnbr_sva.sv
`timescale 1ns/10ps
module lnbr_sva (input wire CORE_CLK, RSTN, SCL_PIN, EN_PIN, VCTRL_PIN, WR_ARMED,
  input wire [7:0] WR_ADDR, WR_DATA, RD_ADDR, RD_DATA,
  input wire WR_DONE, WR_REFUSED, BUS_CONTROL, LIGHT_LOAD_FORCED, DOUBLE_RATE_TONE,
  input wire TONE_SWING_HIGH, input wire [3:0] LEVEL_CODE, input wire OUT_ENABLE);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // done pulse comes one edge after commit; fields one edge after that
  wire p = WR_DONE && WR_ADDR == 8'h00;
  wire s = WR_DONE && WR_ADDR == 8'h01;
  AST_DEC: assert property (WR_DONE |-> $past(WR_ADDR) < 8'h02)
    else $error("bad decode");
  AST_REF: assert property (WR_REFUSED |-> $past(WR_ADDR) > 8'h01)
    else $error("bad refuse");
  AST_LL: assert property (WR_DONE && $past(WR_ADDR) == 8'h00
    |=> LIGHT_LOAD_FORCED == $past(WR_DATA[6], 2)) else $error("ll");
  AST_LVL: assert property (WR_DONE && $past(WR_ADDR) == 8'h00 && $past(WR_DATA[7])
    |=> LEVEL_CODE == $past(WR_DATA[4:1], 2)) else $error("lvl");
  AST_DT: assert property (WR_DONE && $past(WR_ADDR) == 8'h00
    |=> DOUBLE_RATE_TONE == $past(WR_DATA[0], 2)) else $error("tone");
  AST_TS: assert property (WR_DONE && $past(WR_ADDR) == 8'h01
    |=> TONE_SWING_HIGH == $past(WR_DATA[7], 2)) else $error("swing");
  AST_EN: assert property (WR_DONE && $past(WR_ADDR) == 8'h01 && BUS_CONTROL
    |=> OUT_ENABLE == $past(WR_DATA[3], 2)) else $error("en");
  AST_EDGE: assert property (WR_DONE |-> $past(WR_ARMED) && !$past(SCL_PIN, 3)
    && $past(SCL_PIN, 4)) else $error("no fall");
  AST_HOLD: assert property ($changed({BUS_CONTROL, TONE_SWING_HIGH}) |-> $past(WR_DONE))
    else $error("drift");
  cover property (p && WR_DATA[7]);
  cover property (WR_REFUSED);
  cover property (!BUS_CONTROL && OUT_ENABLE);
endmodule // lnbr_sva
bind lnbr_regs lnbr_sva lnbr_sva_inst (.*);

// File: core/lnbr_defines.vh
`ifndef LNBR_DEFINES_VH
`define LNBR_DEFINES_VH

// register indices
`define LNBR_OFS_PRIMARY 8'h00
`define LNBR_OFS_SECONDARY 8'h01

// primary register fields
`define LNBR_BIT_BUS_CTRL 7
`define LNBR_BIT_LIGHT_LOAD 6
`define LNBR_BIT_SPARE 5
`define LNBR_LVL_MSB 4
`define LNBR_LVL_LSB 1
`define LNBR_BIT_DBL_TONE 0

// secondary register fields
`define LNBR_BIT_TONE_SWING 7
`define LNBR_BIT_OUT_EN 3

// reset values
`define LNBR_RST_PRIMARY 8'h08
`define LNBR_RST_SECONDARY 8'h08
`define LNBR_RST_LEVEL 4'h4

// level codes chosen by the pins when bus control is off
`define LNBR_PIN_LVL_HH 4'he
`define LNBR_PIN_LVL_HL 4'h6
`define LNBR_PIN_LVL_LH 4'hc
`define LNBR_PIN_LVL_LL 4'h4

`define LNBR_BYTE_ZERO 8'h00

`endif

// File: core/lnbr_regs.v
`timescale 1ns/10ps
`include "lnbr_defines.vh"
module lnbr_regs (
  input wire CORE_CLK, // core clock, 100 MHz
  input wire RSTN, // async reset, active low
  input wire SCL_PIN, // bus clock pin, also a level select in pin mode
  input wire EN_PIN, // enable pin
  input wire VCTRL_PIN, // voltage select pin
  input wire WR_ARMED, // protocol engine: data byte lsb is on the bus
  input wire [7:0] WR_ADDR, // register index of the pending write
  input wire [7:0] WR_DATA, // data byte of the pending write
  input wire [7:0] RD_ADDR, // register index to read
  output reg [7:0] RD_DATA, // read data, one cycle after RD_ADDR
  output reg WR_DONE, // pulse: write committed
  output reg WR_REFUSED, // pulse: write to unmapped index dropped
  output reg BUS_CONTROL, // level owned by register
  output reg LIGHT_LOAD_FORCED, // forced fixed-frequency switching
  output reg DOUBLE_RATE_TONE, // external double-rate tone passed through
  output reg TONE_SWING_HIGH, // high tone amplitude
  output reg [3:0] LEVEL_CODE, // level code to the regulator core
  output reg OUT_ENABLE // antenna supply output enabled
);
  wire [2:0] pins_sync;
  reg scl_prev_q;
  reg [7:0] primary_q;
  reg [7:0] primary_d;
  reg [7:0] secondary_q;
  reg [7:0] secondary_d;
  reg [3:0] level_d;
  reg enable_d;
  reg [7:0] rd_d;
  wire scl_s;
  wire en_s;
  wire vctrl_s;
  wire scl_fall;
  wire commit;
  wire hit_primary;
  wire hit_secondary;
  wire wr_primary;
  wire wr_secondary;
  wire wr_mapped;
  wire bus_ctrl_bit;
  wire light_load_bit;
  wire dbl_tone_bit;
  wire swing_bit;
  wire out_en_bit;
  wire [3:0] level_bits;

  lnbr_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .async_in({SCL_PIN, EN_PIN, VCTRL_PIN}),
    .sync_out(pins_sync)
  );

  assign scl_s = pins_sync[2];
  assign en_s = pins_sync[1];
  assign vctrl_s = pins_sync[0];

  // engine arms on the lsb; the byte lands on the bus clock falling edge
  assign scl_fall = scl_prev_q & ~scl_s;
  assign commit = WR_ARMED & scl_fall;
  assign hit_primary = (WR_ADDR == `LNBR_OFS_PRIMARY);
  assign hit_secondary = (WR_ADDR == `LNBR_OFS_SECONDARY);

  assign wr_primary = commit & hit_primary;
  assign wr_secondary = commit & hit_secondary;
  assign wr_mapped = wr_primary | wr_secondary;

  // committed field values, named once for the output stages
  assign bus_ctrl_bit = primary_q[`LNBR_BIT_BUS_CTRL];
  assign light_load_bit = primary_q[`LNBR_BIT_LIGHT_LOAD];
  assign dbl_tone_bit = primary_q[`LNBR_BIT_DBL_TONE];
  assign level_bits = primary_q[`LNBR_LVL_MSB:`LNBR_LVL_LSB];
  assign swing_bit = secondary_q[`LNBR_BIT_TONE_SWING];
  assign out_en_bit = secondary_q[`LNBR_BIT_OUT_EN];

  always @* begin
    primary_d = primary_q;
    secondary_d = secondary_q;
    if (commit && hit_primary) begin
      primary_d = WR_DATA;
    end
    if (commit && hit_secondary) begin
      secondary_d = WR_DATA;
    end
  end

  // pin mode level follows the logic table; uses committed register values
  always @* begin
    if (primary_q[`LNBR_BIT_BUS_CTRL]) begin
      level_d = primary_q[`LNBR_LVL_MSB:`LNBR_LVL_LSB];
      enable_d = secondary_q[`LNBR_BIT_OUT_EN];
    end else begin
      case ({scl_s, vctrl_s})
        2'b11: level_d = `LNBR_PIN_LVL_HH;
        2'b10: level_d = `LNBR_PIN_LVL_HL;
        2'b01: level_d = `LNBR_PIN_LVL_LH;
        default: level_d = `LNBR_PIN_LVL_LL;
      endcase
      // enable pin low forces the output off in pin mode
      enable_d = en_s & secondary_q[`LNBR_BIT_OUT_EN];
    end
  end

  always @* begin
    case (RD_ADDR)
      `LNBR_OFS_PRIMARY: rd_d = primary_q;
      `LNBR_OFS_SECONDARY: rd_d = secondary_q;
      default: rd_d = `LNBR_BYTE_ZERO;
    endcase
  end

  // idle low so the first synced high after reset is no false fall
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      primary_q <= `LNBR_RST_PRIMARY;
    end else begin
      primary_q <= primary_d;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      secondary_q <= `LNBR_RST_SECONDARY;
    end else begin
      secondary_q <= secondary_d;
    end
  end

  // outputs registered; bit 5 deliberately drives nothing
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_DATA <= `LNBR_BYTE_ZERO;
    end else begin
      RD_DATA <= rd_d;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WR_DONE <= 1'b0;
    end else begin
      WR_DONE <= wr_mapped;
    end
  end

  // unmapped index: byte dropped, engine still told
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WR_REFUSED <= 1'b0;
    end else begin
      WR_REFUSED <= commit & ~(hit_primary | hit_secondary);
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_CONTROL <= 1'b0;
    end else begin
      BUS_CONTROL <= bus_ctrl_bit;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LIGHT_LOAD_FORCED <= 1'b0;
    end else begin
      LIGHT_LOAD_FORCED <= light_load_bit;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DOUBLE_RATE_TONE <= 1'b0;
    end else begin
      DOUBLE_RATE_TONE <= dbl_tone_bit;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TONE_SWING_HIGH <= 1'b0;
    end else begin
      TONE_SWING_HIGH <= swing_bit;
    end
  end

  // level_d already picks register code or pin table
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LEVEL_CODE <= `LNBR_RST_LEVEL;
    end else begin
      LEVEL_CODE <= level_d;
    end
  end

  // held off in reset until the enable pin has been synced
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      OUT_ENABLE <= 1'b0;
    end else begin
      OUT_ENABLE <= enable_d;
    end
  end
endmodule // lnbr_regs

// File: core/lnbr_sync.v
`timescale 1ns/10ps
module lnbr_sync #(
  parameter WIDTH = 1
) (
  input wire clk, // sampling clock
  input wire rst_n, // async reset, active low
  input wire [WIDTH-1:0] async_in, // signals from outside the domain
  output reg [WIDTH-1:0] sync_out // synchronised copy
);
  reg [WIDTH-1:0] meta_q;

  // first stage is read only by the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // lnbr_sync
